//--- core/dhtrtc_regs.svh
// register offsets, field positions, reset values and mode codes
`ifndef DHTRTC_REGS_SVH
`define DHTRTC_REGS_SVH
`define DHT_OFF_CFG 8'h00
`define DHT_OFF_AMODE 8'h04
`define DHT_OFF_BMODE 8'h08
`define DHT_OFF_CTL 8'h0C
`define DHT_OFF_MASK 8'h18
`define DHT_OFF_RAW 8'h1C
`define DHT_OFF_MIS 8'h20
`define DHT_OFF_CLR 8'h24
`define DHT_OFF_ALOAD 8'h28
`define DHT_OFF_BLOAD 8'h2C
`define DHT_OFF_AMATCH 8'h30
`define DHT_OFF_APRE 8'h38
`define DHT_OFF_BPRE 8'h3C
`define DHT_OFF_ACNT 8'h48
`define DHT_OFF_BCNT 8'h4C
`define DHT_CFG_JOIN 3'h0
`define DHT_CFG_CLOCK 3'h1
`define DHT_CFG_SPLIT 3'h4
`define DHT_MODE_ONE 2'h1
`define DHT_MODE_PER 2'h2
`define DHT_CTL_AEN 0
`define DHT_CTL_AFRZ 1
`define DHT_CTL_OVR 4
`define DHT_CTL_AOTE 5
`define DHT_CTL_BEN 8
`define DHT_CTL_BFRZ 9
`define DHT_CTL_BOTE 13
`define DHT_IRQ_ATO 0
`define DHT_IRQ_MATCH 3
`define DHT_IRQ_BTO 8
`define DHT_CNT_RST 16'hFFFF
`define DHT_PRE_RST 8'h00
`define DHT_CLOCK_FIRST 32'h00000001
`define DHT_MATCH_RST 32'hFFFFFFFF
`endif

//--- core/dhtrtc_pkg.sv
// types of the dual half timer
package dhtrtc_pkg;
   typedef logic [7:0] dhtrtc_addr_type;
   typedef logic [31:0] dhtrtc_word_type;
endpackage

//--- core/dhtrtc_core.sv
// dual half timer with joined real-time clock
`timescale 1ns/1ps
`include "dhtrtc_regs.svh"
module dhtrtc_core (
   input wire logic i_core_clk,
   input wire logic i_sys_rst,
   input wire dhtrtc_pkg::dhtrtc_addr_type i_addr,
   input wire dhtrtc_pkg::dhtrtc_word_type i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output dhtrtc_pkg::dhtrtc_word_type o_rdata,
   input wire logic i_slow_clock_input,
   output logic [1:0] o_trigger,
   output logic [1:0] o_irq_masked
);
   import dhtrtc_pkg::*;

   // ************************************************
   // registers and state
   // ************************************************
   logic [2:0] width_config_reg;
   logic [1:0] half_a_mode_reg;
   logic [1:0] half_b_mode_reg;
   logic [15:0] timer_control_reg;
   logic [15:0] irq_mask_reg;
   logic [15:0] raw_irq_status;
   logic [15:0] load_reg [2];
   logic [7:0] pre_reg [2];
   logic [7:0] pcnt_reg [2];
   logic [15:0] cnt_reg [2];
   logic [31:0] half_a_match_reg;
   logic clock_seen_reg;
   logic [2:0] slow_sync_reg;
   logic slow_level_reg;
   logic slow_edge;
   logic [1:0] zero_hit;
   logic match_hit;
   logic joined;
   logic clock_mode;

   // write decode helper
   function automatic logic wr_at(input dhtrtc_addr_type a,
                                  input dhtrtc_addr_type off,
                                  input logic we);
      wr_at = we && (a == off);
   endfunction

   assign joined = (width_config_reg != `DHT_CFG_SPLIT);
   assign clock_mode = (width_config_reg == `DHT_CFG_CLOCK);

   // slow clock three-stage sampler, edge once stages two and three agree
   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         slow_sync_reg <= 3'h0;
         slow_level_reg <= 1'b0;
      end else begin
         slow_sync_reg <= {slow_sync_reg[1:0], i_slow_clock_input};
         if (slow_sync_reg[1] == slow_sync_reg[2]) begin
            slow_level_reg <= slow_sync_reg[2]; // agreed level only
         end
      end
   end
   // rising edge counted once, when the agreed level turns high
   assign slow_edge = slow_sync_reg[1] && slow_sync_reg[2] &&
                      !slow_level_reg;

   // ************************************************
   // configuration registers
   // ************************************************
   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         width_config_reg <= 3'h0;
         half_a_mode_reg <= 2'h0;
         half_b_mode_reg <= 2'h0;
         irq_mask_reg <= 16'h0000;
         half_a_match_reg <= `DHT_MATCH_RST;
      end else begin
         if (wr_at(i_addr, `DHT_OFF_CFG, i_wr)) begin
            width_config_reg <= i_wdata[2:0];
         end
         if (wr_at(i_addr, `DHT_OFF_AMODE, i_wr)) begin
            half_a_mode_reg <= i_wdata[1:0];
         end
         if (wr_at(i_addr, `DHT_OFF_BMODE, i_wr)) begin
            half_b_mode_reg <= i_wdata[1:0];
         end
         if (wr_at(i_addr, `DHT_OFF_MASK, i_wr)) begin
            irq_mask_reg <= i_wdata[15:0];
         end
         if (wr_at(i_addr, `DHT_OFF_AMATCH, i_wr)) begin
            half_a_match_reg <= i_wdata;
         end
      end
   end

   // control register, hardware clears enable on one-shot expiry
   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         timer_control_reg <= 16'h0000;
      end else begin
         if (wr_at(i_addr, `DHT_OFF_CTL, i_wr)) begin
            timer_control_reg <= i_wdata[15:0];
         end else begin
            if (zero_hit[0] && half_a_mode_reg == `DHT_MODE_ONE) begin
               timer_control_reg[`DHT_CTL_AEN] <= 1'b0;
            end
            if (zero_hit[1] && !joined &&
                half_b_mode_reg == `DHT_MODE_ONE) begin
               timer_control_reg[`DHT_CTL_BEN] <= 1'b0;
            end
         end
      end
   end

   // load and prescale registers, joined write fills both halves
   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         load_reg[0] <= `DHT_CNT_RST;
         load_reg[1] <= `DHT_CNT_RST;
         pre_reg[0] <= `DHT_PRE_RST;
         pre_reg[1] <= `DHT_PRE_RST;
      end else begin
         if (wr_at(i_addr, `DHT_OFF_ALOAD, i_wr)) begin
            load_reg[0] <= i_wdata[15:0];
            if (joined) begin
               load_reg[1] <= i_wdata[31:16];
            end
         end
         if (wr_at(i_addr, `DHT_OFF_BLOAD, i_wr)) begin
            load_reg[1] <= i_wdata[15:0];
         end
         if (wr_at(i_addr, `DHT_OFF_APRE, i_wr)) begin
            pre_reg[0] <= i_wdata[7:0];
         end
         if (wr_at(i_addr, `DHT_OFF_BPRE, i_wr)) begin
            pre_reg[1] <= i_wdata[7:0];
         end
      end
   end

   // ************************************************
   // counters
   // ************************************************
   logic [1:0] en;
   logic [1:0] frz;
   logic [1:0] step;
   logic [1:0] load_wr;
   logic [31:0] joined_cnt;
   logic joined_step;
   logic clock_run;

   assign en = {timer_control_reg[`DHT_CTL_BEN],
                timer_control_reg[`DHT_CTL_AEN]};
   assign frz = {timer_control_reg[`DHT_CTL_BFRZ],
                 timer_control_reg[`DHT_CTL_AFRZ]};
   assign load_wr[0] = wr_at(i_addr, `DHT_OFF_ALOAD, i_wr);
   assign load_wr[1] = wr_at(i_addr, `DHT_OFF_BLOAD, i_wr) ||
                       (joined && load_wr[0]);
   assign joined_cnt = {cnt_reg[1], cnt_reg[0]};
   assign joined_step = en[0] && !frz[0];
   assign clock_run = en[0] && slow_edge &&
                      (timer_control_reg[`DHT_CTL_OVR] ||
                       frz == 2'b00);
   assign match_hit = clock_mode && clock_run &&
                      joined_cnt == half_a_match_reg;

   // prescale step pulses for the split halves
   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_pre
         assign step[g] = en[g] && !frz[g] &&
                          pcnt_reg[g] == 8'h00;
         always_ff @(posedge i_core_clk) begin
            if (i_sys_rst) begin
               pcnt_reg[g] <= `DHT_PRE_RST;
            end else if (joined || load_wr[g]) begin
               pcnt_reg[g] <= pre_reg[g];
            end else if (en[g] && !frz[g]) begin
               if (pcnt_reg[g] == 8'h00) begin
                  pcnt_reg[g] <= pre_reg[g];
               end else begin
                  pcnt_reg[g] <= pcnt_reg[g] - 8'h01;
               end
            end
         end
      end
   endgenerate

   // time-out detection at the zero state
   always_comb begin
      zero_hit = 2'b00;
      if (joined && !clock_mode) begin
         zero_hit[0] = joined_step && joined_cnt == 32'h00000000;
      end else if (!joined) begin
         zero_hit[0] = step[0] && cnt_reg[0] == 16'h0000;
         zero_hit[1] = step[1] && cnt_reg[1] == 16'h0000;
      end
   end

   // count update for joined timer, joined clock and split halves
   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         cnt_reg[0] <= `DHT_CNT_RST;
         cnt_reg[1] <= `DHT_CNT_RST;
         clock_seen_reg <= 1'b0;
      end else if (clock_mode) begin
         if (!clock_seen_reg) begin
            {cnt_reg[1], cnt_reg[0]} <= `DHT_CLOCK_FIRST;
            clock_seen_reg <= 1'b1;
         end else if (wr_at(i_addr, `DHT_OFF_AMATCH, i_wr) && !en[0]) begin
            {cnt_reg[1], cnt_reg[0]} <= i_wdata;
         end else if (match_hit) begin
            {cnt_reg[1], cnt_reg[0]} <= 32'h00000000;
         end else if (clock_run) begin
            {cnt_reg[1], cnt_reg[0]} <= joined_cnt + 32'h00000001;
         end
      end else if (joined) begin
         if (load_wr[0]) begin
            {cnt_reg[1], cnt_reg[0]} <= i_wdata;
         end else if (zero_hit[0]) begin
            {cnt_reg[1], cnt_reg[0]} <= {load_reg[1], load_reg[0]};
         end else if (joined_step) begin
            {cnt_reg[1], cnt_reg[0]} <= joined_cnt - 32'h00000001;
         end
      end else begin
         for (int h = 0; h < 2; h++) begin
            if (load_wr[h]) begin
               cnt_reg[h] <= h == 0 ? i_wdata[15:0] : i_wdata[15:0];
            end else if (zero_hit[h]) begin
               cnt_reg[h] <= load_reg[h];
            end else if (step[h]) begin
               cnt_reg[h] <= cnt_reg[h] - 16'h0001;
            end
         end
      end
   end

   // ************************************************
   // status flags and trigger outputs
   // ************************************************
   logic [15:0] clr;
   logic [15:0] set;
   assign clr = wr_at(i_addr, `DHT_OFF_CLR, i_wr) ? i_wdata[15:0] :
                16'h0000;
   always_comb begin
      set = 16'h0000;
      set[`DHT_IRQ_ATO] = zero_hit[0];
      set[`DHT_IRQ_BTO] = zero_hit[1];
      set[`DHT_IRQ_MATCH] = match_hit;
   end

   // sticky flags, a set in the clearing cycle wins
   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         raw_irq_status <= 16'h0000;
      end else begin
         raw_irq_status <= (raw_irq_status & ~clr) | set;
      end
   end

   // masked flags and one-cycle triggers
   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         o_irq_masked <= 2'b00;
         o_trigger <= 2'b00;
      end else begin
         o_irq_masked[0] <= |(((raw_irq_status & ~clr) | set) &
                             irq_mask_reg & 16'h00FF);
         o_irq_masked[1] <= |(((raw_irq_status & ~clr) | set) &
                             irq_mask_reg & 16'hFF00);
         o_trigger[0] <= zero_hit[0] &&
                         timer_control_reg[`DHT_CTL_AOTE];
         o_trigger[1] <= zero_hit[1] &&
                         timer_control_reg[`DHT_CTL_BOTE];
      end
   end

   // ************************************************
   // read port
   // ************************************************
   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         o_rdata <= 32'h00000000;
      end else if (i_rd) begin
         unique case (i_addr)
            `DHT_OFF_CFG: o_rdata <= {29'h0, width_config_reg};
            `DHT_OFF_AMODE: o_rdata <= {30'h0, half_a_mode_reg};
            `DHT_OFF_BMODE: o_rdata <= {30'h0, half_b_mode_reg};
            `DHT_OFF_CTL: o_rdata <= {16'h0, timer_control_reg};
            `DHT_OFF_MASK: o_rdata <= {16'h0, irq_mask_reg};
            `DHT_OFF_RAW: o_rdata <= {16'h0, raw_irq_status};
            `DHT_OFF_MIS: o_rdata <= {16'h0, raw_irq_status & irq_mask_reg};
            `DHT_OFF_ALOAD: o_rdata <= joined ?
               {load_reg[1], load_reg[0]} : {16'h0, load_reg[0]};
            `DHT_OFF_BLOAD: o_rdata <= {16'h0, load_reg[1]};
            `DHT_OFF_AMATCH: o_rdata <= half_a_match_reg;
            `DHT_OFF_APRE: o_rdata <= {24'h0, pre_reg[0]};
            `DHT_OFF_BPRE: o_rdata <= {24'h0, pre_reg[1]};
            `DHT_OFF_ACNT: o_rdata <= joined ? joined_cnt :
               {16'h0, cnt_reg[0]};
            `DHT_OFF_BCNT: o_rdata <= {16'h0, cnt_reg[1]};
            default: o_rdata <= 32'h00000000;
         endcase
      end else begin
         o_rdata <= 32'h00000000;
      end
   end

   // ************************************************
   // checks
   // ************************************************
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (i_sys_rst);

   trig_one_cycle_a: assert property (o_trigger[0] |=> !o_trigger[0])
      else $error("trigger longer than one cycle");
   trig_cause_a: assert property (o_trigger[0] |->
      $past(zero_hit[0] && timer_control_reg[`DHT_CTL_AOTE]))
      else $error("trigger without zero");
   raw_sticky_a: assert property (set[`DHT_IRQ_ATO] |=>
      raw_irq_status[`DHT_IRQ_ATO])
      else $error("time-out flag lost");
   reload_zero_a: assert property ((zero_hit[0] && joined && !load_wr[0])
      |=> joined_cnt == $past({load_reg[1], load_reg[0]}))
      else $error("no reload after zero");
   one_shot_stop_a: assert property ((zero_hit[0] && !i_wr &&
      half_a_mode_reg == `DHT_MODE_ONE) |=> !en[0])
      else $error("one-shot still enabled");
   split_b_stop_a: assert property ((zero_hit[1] && !i_wr &&
      half_b_mode_reg == `DHT_MODE_ONE) |=> !en[1])
      else $error("split one-shot still enabled");
   irq_level_a: assert property (o_irq_masked[0] ==
      |(raw_irq_status & $past(irq_mask_reg) & 16'h00FF))
      else $error("masked output disagrees with flags");
   freeze_hold_a: assert property ((!clock_mode && frz[0] && !load_wr[0] &&
      !$past(i_sys_rst)) |=> $stable(cnt_reg[0]))
      else $error("frozen counter moved");
   match_roll_a: assert property ((match_hit && !i_wr) |=>
      joined_cnt == 32'h00000000)
      else $error("no rollover at match");
   load_next_a: assert property ((load_wr[0] && joined && !clock_mode) |=>
      joined_cnt == $past(i_wdata))
      else $error("load not taken");
   match_flag_a: assert property (match_hit |=>
      raw_irq_status[`DHT_IRQ_MATCH])
      else $error("match flag lost");

   cov_joined_zero: cover property (zero_hit[0] && joined);
   cov_split_b_zero: cover property (zero_hit[1]);
   cov_clock_match: cover property (match_hit);
   cov_trigger: cover property (o_trigger[0]);
   cov_frozen: cover property (frz[0] && en[0] && !clock_mode);
endmodule

//--- dv/dhtrtc_core_tb.sv
// self-checking testbench for the dual half timer core
`timescale 1ns/1ps
`include "dhtrtc_regs.svh"
module dhtrtc_core_tb;
   import dhtrtc_pkg::*;
   logic i_core_clk;
   logic i_sys_rst;
   dhtrtc_addr_type i_addr;
   dhtrtc_word_type i_wdata;
   logic i_wr;
   logic i_rd;
   dhtrtc_word_type o_rdata;
   logic i_slow_clock_input;
   logic [1:0] o_trigger;
   logic [1:0] o_irq_masked;
   logic slow_run;
   int slow_cnt;
   int mismatches;
   int tests_run;
   int n;
   dhtrtc_word_type rv;
   dhtrtc_word_type rv2;

   dhtrtc_core DUT (
      .i_core_clk(i_core_clk),
      .i_sys_rst(i_sys_rst),
      .i_addr(i_addr),
      .i_wdata(i_wdata),
      .i_wr(i_wr),
      .i_rd(i_rd),
      .o_rdata(o_rdata),
      .i_slow_clock_input(i_slow_clock_input),
      .o_trigger(o_trigger),
      .o_irq_masked(o_irq_masked)
   );

   // ****************************************
   // clocks
   // ****************************************
   // system clock, 100 MHz
   initial begin
      i_core_clk = 1'b0;
      forever #5 i_core_clk = ~i_core_clk;
   end

   // slow input, one toggle every 15 system clocks while running
   always @(posedge i_core_clk) begin
      if (slow_run) begin
         if (slow_cnt == 14) begin
            slow_cnt <= 0;
            i_slow_clock_input <= ~i_slow_clock_input;
         end else begin
            slow_cnt <= slow_cnt + 1;
         end
      end
   end

   // ****************************************
   // bus and check helpers
   // ****************************************
   task automatic chk(input dhtrtc_word_type got, input dhtrtc_word_type exp,
                      input string what);
      tests_run++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value at %0t: %s got %h exp %h", $time, what, got,
                  exp);
      end
   endtask

   task automatic wr(input dhtrtc_addr_type a, input dhtrtc_word_type d);
      @(posedge i_core_clk);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_core_clk);
      i_wr <= 1'b0;
   endtask

   // read data stands in the cycle after the strobe is taken
   task automatic rd(input dhtrtc_addr_type a, output dhtrtc_word_type d);
      @(posedge i_core_clk);
      i_rd <= 1'b1;
      i_addr <= a;
      @(posedge i_core_clk);
      i_rd <= 1'b0;
      #1;
      d = o_rdata;
   endtask

   // waits for a trigger pulse, returns the cycles taken
   task automatic wait_trig(input int b, output int cyc);
      cyc = 0;
      do begin
         @(posedge i_core_clk);
         #1;
         cyc++;
      end while (o_trigger[b] !== 1'b1 && cyc < 2000);
   endtask

   // ****************************************
   // scenarios
   // ****************************************
   task automatic t_reset;
      rd(`DHT_OFF_ACNT, rv);
      chk(rv, 32'hFFFFFFFF, "joined count");
      rd(`DHT_OFF_BLOAD, rv);
      chk({16'h0000, rv[15:0]}, 32'h0000FFFF, "b load");
      rd(`DHT_OFF_APRE, rv);
      chk(rv, 32'h00000000, "a prescale");
      rd(`DHT_OFF_BPRE, rv);
      chk(rv, 32'h00000000, "b prescale");
      rd(`DHT_OFF_CTL, rv);
      chk(rv, 32'h00000000, "control");
      rd(8'h70, rv);
      chk(rv, 32'h00000000, "unmapped read");
   endtask

   task automatic t_oneshot;
      wr(`DHT_OFF_BMODE, 32'h00000002);
      wr(`DHT_OFF_AMODE, 32'h00000001);
      wr(`DHT_OFF_MASK, 32'h00000001);
      wr(`DHT_OFF_ALOAD, 32'h00030000);
      rd(`DHT_OFF_BLOAD, rv);
      chk({16'h0000, rv[15:0]}, 32'h00000003, "split load");
      rd(`DHT_OFF_ACNT, rv);
      chk(rv, 32'h00030000, "joined load");
      wr(`DHT_OFF_ALOAD, 32'h00000008);
      wr(`DHT_OFF_CTL, 32'h00000021);
      wait_trig(0, n);
      chk({31'h0, n >= 8 && n <= 16}, 32'h1, "time to zero");
      @(posedge i_core_clk);
      #1;
      chk({31'h0, o_trigger[0]}, 32'h0, "pulse width");
      rd(`DHT_OFF_RAW, rv);
      chk(rv, 32'h00000001, "raw timeout");
      rd(`DHT_OFF_MIS, rv);
      chk(rv, 32'h00000001, "masked timeout");
      chk({30'h0, o_irq_masked}, 32'h1, "irq out");
      rd(`DHT_OFF_CTL, rv);
      chk(rv, 32'h00000020, "one-shot stop");
      rd(`DHT_OFF_ACNT, rv);
      chk(rv, 32'h00000008, "reload");
      wr(`DHT_OFF_CLR, 32'h00000001);
      rd(`DHT_OFF_RAW, rv);
      chk(rv, 32'h00000000, "clear");
   endtask

   task automatic t_periodic;
      wr(`DHT_OFF_AMODE, 32'h00000002);
      wr(`DHT_OFF_ALOAD, 32'h00001000);
      wr(`DHT_OFF_CTL, 32'h00000023);
      repeat (5) @(posedge i_core_clk);
      rd(`DHT_OFF_ACNT, rv);
      chk(rv, 32'h00001000, "frozen");
      wr(`DHT_OFF_CTL, 32'h00000021);
      rd(`DHT_OFF_ACNT, rv);
      chk({31'h0, rv < 32'h00001000}, 32'h1, "resumed");
      wr(`DHT_OFF_ALOAD, 32'h00000020);
      rd(`DHT_OFF_ACNT, rv);
      chk({31'h0, rv <= 32'h20 && rv >= 32'h1C}, 32'h1, "new load");
      wait_trig(0, n);
      wait_trig(0, n);
      chk({31'h0, n >= 32 && n <= 34}, 32'h1, "period");
      rd(`DHT_OFF_CTL, rv);
      chk(rv, 32'h00000021, "still enabled");
      wr(`DHT_OFF_CTL, 32'h00000000);
      wr(`DHT_OFF_CLR, 32'hFFFFFFFF);
   endtask

   task automatic t_split;
      wr(`DHT_OFF_CFG, 32'h00000004);
      wr(`DHT_OFF_BMODE, 32'h00000001);
      wr(`DHT_OFF_BPRE, 32'h00000003);
      wr(`DHT_OFF_BLOAD, 32'h00000005);
      wr(`DHT_OFF_ALOAD, 32'h0000FFFF);
      wr(`DHT_OFF_MASK, 32'h00000100);
      rd(`DHT_OFF_BCNT, rv);
      repeat (4) @(posedge i_core_clk);
      rd(`DHT_OFF_BCNT, rv2);
      chk(rv2, rv, "idle half");
      wr(`DHT_OFF_CTL, 32'h00002101);
      wait_trig(1, n);
      chk({31'h0, n >= 18 && n <= 28}, 32'h1, "prescaled time");
      rd(`DHT_OFF_RAW, rv);
      chk(rv, 32'h00000100, "b timeout only");
      chk({30'h0, o_irq_masked}, 32'h2, "b irq");
      rd(`DHT_OFF_CTL, rv);
      chk(rv & 32'h00000101, 32'h00000001, "b stopped");
      rd(`DHT_OFF_BCNT, rv);
      chk({16'h0000, rv[15:0]}, 32'h00000005, "b reload");
      wr(`DHT_OFF_CTL, 32'h00000000);
      wr(`DHT_OFF_CLR, 32'hFFFFFFFF);
   endtask

   task automatic t_rtc;
      wr(`DHT_OFF_AMATCH, 32'h00000003);
      wr(`DHT_OFF_CFG, 32'h00000001);
      rd(`DHT_OFF_ACNT, rv);
      chk(rv, `DHT_CLOCK_FIRST, "first load");
      wr(`DHT_OFF_MASK, 32'h00000008);
      wr(`DHT_OFF_CTL, 32'h00000013);
      slow_run <= 1'b1;
      n = 0;
      do begin
         rd(`DHT_OFF_RAW, rv);
         n++;
      end while (rv[3] !== 1'b1 && n < 300);
      chk(rv, 32'h00000008, "match raw");
      rd(`DHT_OFF_ACNT, rv);
      chk(rv, 32'h00000000, "roll over");
      chk({31'h0, o_irq_masked[0]}, 32'h1, "match irq");
      slow_run <= 1'b0;
      rd(`DHT_OFF_ACNT, rv);
      repeat (60) @(posedge i_core_clk);
      rd(`DHT_OFF_ACNT, rv2);
      chk(rv2, rv, "no slow edge");
      wr(`DHT_OFF_CLR, 32'h00000008);
      rd(`DHT_OFF_MIS, rv);
      chk(rv, 32'h00000000, "match clear");
      chk({30'h0, o_irq_masked}, 32'h0, "irq cleared");
   endtask

   // ****************************************
   // verdict, watchdog and main sequence
   // ****************************************
   task automatic print_verdict;
      if (mismatches == 0 && tests_run > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // roughly twenty-five times the expected run
   initial begin
      repeat (10000) @(posedge i_core_clk);
      mismatches++;
      print_verdict();
   end

   initial begin
      i_sys_rst = 1'b1;
      i_addr = 8'h00;
      i_wdata = 32'h00000000;
      i_wr = 1'b0;
      i_rd = 1'b0;
      i_slow_clock_input = 1'b0;
      slow_run = 1'b0;
      slow_cnt = 0;
      mismatches = 0;
      tests_run = 0;
      repeat (6) @(posedge i_core_clk);
      i_sys_rst <= 1'b0;
      t_reset();
      t_oneshot();
      t_periodic();
      t_split();
      t_rtc();
      print_verdict();
   end
endmodule
